/* File: common/dac_ctrl_pkg.sv */
// Shared constants, codes and state type of the DAC load and busy control block.
package dac_ctrl_pkg;
    // ==========================================================
    // Geometry
    localparam int NUM_CH = 40;
    localparam int CH_W = 6;
    localparam int DATA_W = 12;
    localparam logic [CH_W-1:0] NUM_CH_LIMIT = 6'h28;

    // ==========================================================
    // Register select codes {register_select_high, register_select_low}
    localparam logic [1:0] REGSEL_SFR = 2'h0;
    localparam logic [1:0] REGSEL_GAIN = 2'h1;
    localparam logic [1:0] REGSEL_OFFSET = 2'h2;
    localparam logic [1:0] REGSEL_INPUT = 2'h3;

    // ==========================================================
    // Special function register addresses and fields
    localparam logic [CH_W-1:0] SFR_CLEAR_CODE = 6'h00;
    localparam logic [CH_W-1:0] SFR_CONTROL = 6'h01;
    localparam int CTRL_TOGGLE_BIT = 0;

    // ==========================================================
    // Reset values and code limits
    localparam logic [DATA_W-1:0] INPUT_RESET = 12'h000;
    localparam logic [DATA_W-1:0] GAIN_RESET = 12'hfff;
    localparam logic [DATA_W-1:0] OFFSET_RESET = 12'h800;
    localparam logic [DATA_W-1:0] CLEAR_CODE_RESET = 12'h000;
    localparam logic [DATA_W-1:0] OUTPUT_RESET = 12'h000;
    localparam logic [DATA_W-1:0] CODE_MID = 12'h800;
    localparam logic [DATA_W-1:0] CODE_MAX = 12'hfff;

    // ==========================================================
    // Serial readback pins shared with the parallel data bus
    localparam int SERIAL_CLK_BIT = 10;
    localparam int SERIAL_DIN_BIT = 11;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLEAR_TIME_NS = 35000;
    localparam int RESET_TIME_NS = 270000;
    localparam int CLEAR_CYCLES_DEF = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYCLES_DEF = RESET_TIME_NS / CLK_PERIOD_NS;
    localparam int CALC_CYCLES = 8;
    localparam int CNT_W = 17;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_IDLE = 2'b01,
        ST_CALC = 2'b10,
        ST_CLEAR = 2'b11
    } seq_state_e;
endpackage

/* File: logic/pin_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Pins and synchronised copy
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* File: logic/code_calc.sv */
// Computed output code from input code, gain and offset, clamped to full scale.
`timescale 1ns/100ps
`default_nettype none
module code_calc (
    // Channel operands
    input wire logic [dac_ctrl_pkg::DATA_W-1:0] i_input_code,
    input wire logic [dac_ctrl_pkg::DATA_W-1:0] i_gain,
    input wire logic [dac_ctrl_pkg::DATA_W-1:0] i_offset,
    // Result
    output logic [dac_ctrl_pkg::DATA_W-1:0] o_computed_code
);
    import dac_ctrl_pkg::*;

    logic [2*DATA_W:0] product;
    logic signed [DATA_W+2:0] sum;

    always_comb begin
        product = i_input_code * ({1'b0, i_gain} + 13'h001);
        sum = $signed({2'b00, product[2*DATA_W:DATA_W]}) + $signed({3'b000, i_offset})
            - $signed({3'b000, CODE_MID});
        if (sum < 0) begin
            o_computed_code = '0;
        end else if (sum > $signed({3'b000, CODE_MAX})) begin
            o_computed_code = CODE_MAX;
        end else begin
            o_computed_code = sum[DATA_W-1:0];
        end
    end
endmodule
`default_nettype wire

/* File: logic/dac_load_busy_control.sv */
// Control logic of a 40-channel DAC: register decode, load strobe, busy, clear and reset.
`timescale 1ns/100ps
`default_nettype none
module dac_load_busy_control #(
    parameter int CLEAR_CYCLES = dac_ctrl_pkg::CLEAR_CYCLES_DEF,
    parameter int RESET_CYCLES = dac_ctrl_pkg::RESET_CYCLES_DEF
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Parallel write bus
    input wire logic [dac_ctrl_pkg::DATA_W-1:0] i_parallel_data_bus,
    input wire logic [dac_ctrl_pkg::CH_W-1:0] i_channel_address_inputs,
    input wire logic i_register_select_high,
    input wire logic i_register_select_low,
    input wire logic i_chip_select_n,
    input wire logic i_write_n,
    input wire logic i_interface_select,
    // Hardware control pins
    input wire logic i_load_outputs_strobe_n,
    input wire logic i_clear_to_code_input_n,
    input wire logic i_reset_pin_n,
    input wire logic [dac_ctrl_pkg::CH_W-1:0] i_readback_channel,
    // Shared bank select and serial readback pin
    input wire logic i_bank_select,
    output logic o_serial_readback_output,
    output logic o_serial_readback_oe,
    // Status and channel codes
    output logic o_busy_n,
    output logic [dac_ctrl_pkg::NUM_CH*dac_ctrl_pkg::DATA_W-1:0] o_dac_code
);
    import dac_ctrl_pkg::*;

    // ==========================================================
    // Pin synchronisation and edge detection
    localparam int CTRL_W = 5;
    localparam int DPIN_W = 2 + 2 + 2 * CH_W + DATA_W;

    logic [CTRL_W-1:0] s_ctrl;
    logic [DPIN_W-1:0] s_dpin;
    logic s_cs_n;
    logic s_wr_n;
    logic s_load_n;
    logic s_clr_n;
    logic s_rst_n;
    logic s_iface;
    logic s_bank;
    logic [1:0] s_regsel;
    logic [CH_W-1:0] s_addr;
    logic [CH_W-1:0] s_rb_ch;
    logic [DATA_W-1:0] s_data;
    logic s_sclk;

    pin_sync #(.WIDTH(CTRL_W), .RESET_VAL('1)) u_ctrl_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async({i_chip_select_n, i_write_n, i_load_outputs_strobe_n,
                  i_clear_to_code_input_n, i_reset_pin_n}),
        .o_sync(s_ctrl)
    );

    pin_sync #(.WIDTH(DPIN_W), .RESET_VAL('0)) u_data_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async({i_interface_select, i_bank_select, i_register_select_high,
                  i_register_select_low, i_channel_address_inputs, i_readback_channel,
                  i_parallel_data_bus}),
        .o_sync(s_dpin)
    );

    assign {s_cs_n, s_wr_n, s_load_n, s_clr_n, s_rst_n} = s_ctrl;
    assign {s_iface, s_bank, s_regsel, s_addr, s_rb_ch, s_data} = s_dpin;
    assign s_sclk = s_data[SERIAL_CLK_BIT];

    logic [CTRL_W-1:0] prev_ctrl_q;
    logic [CTRL_W-1:0] prev_ctrl_d;
    logic prev_sclk_q;
    logic prev_sclk_d;

    always_comb begin
        prev_ctrl_d = s_ctrl;
        prev_sclk_d = s_sclk;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prev_ctrl_q <= '1;
            prev_sclk_q <= 1'b0;
        end else begin
            prev_ctrl_q <= prev_ctrl_d;
            prev_sclk_q <= prev_sclk_d;
        end
    end

    logic cs_fall;
    logic wr_rise;
    logic load_fall;
    logic clr_fall;
    logic rst_fall;
    logic sclk_rise;
    logic sclk_fall;

    always_comb begin
        cs_fall = prev_ctrl_q[4] & ~s_cs_n;
        wr_rise = ~prev_ctrl_q[3] & s_wr_n;
        load_fall = prev_ctrl_q[2] & ~s_load_n;
        clr_fall = prev_ctrl_q[1] & ~s_clr_n;
        rst_fall = prev_ctrl_q[0] & ~s_rst_n;
        sclk_rise = ~prev_sclk_q & s_sclk;
        sclk_fall = prev_sclk_q & ~s_sclk;
    end

    // ==========================================================
    // Sequencer, load strobe and special function registers
    seq_state_e state_q;
    seq_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic pend_q;
    logic pend_d;
    logic toggle_q;
    logic toggle_d;
    logic [DATA_W-1:0] clear_code_q;
    logic [DATA_W-1:0] clear_code_d;
    logic busy_n_q;
    logic busy_n_d;
    logic wr_fire;
    logic wr_chan;
    logic wr_b;
    logic rst_start;
    logic code_update;
    logic load_exec;
    logic clear_apply;

    always_comb begin
        wr_fire = ~s_iface & ~s_cs_n & wr_rise & (state_q != ST_RESET);
        wr_chan = wr_fire & (s_regsel != REGSEL_SFR) & (s_addr < NUM_CH_LIMIT);
        wr_b = toggle_q & s_bank;
        rst_start = rst_fall & (state_q != ST_RESET);
        state_d = state_q;
        cnt_d = cnt_q;
        pend_d = pend_q;
        toggle_d = toggle_q;
        clear_code_d = clear_code_q;
        code_update = 1'b0;
        load_exec = 1'b0;
        clear_apply = 1'b0;
        if (wr_fire && s_regsel == REGSEL_SFR) begin
            if (s_addr == SFR_CLEAR_CODE) begin
                clear_code_d = s_data;
            end else if (s_addr == SFR_CONTROL) begin
                toggle_d = s_data[CTRL_TOGGLE_BIT];
            end
        end
        case (state_q)
            ST_RESET: begin
                pend_d = 1'b0;
                if (cnt_q == '0) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_IDLE: begin
                if (load_fall || pend_q) begin
                    load_exec = 1'b1;
                    pend_d = 1'b0;
                end
                if (wr_chan) begin
                    state_d = ST_CALC;
                    cnt_d = CNT_W'(CALC_CYCLES - 1);
                end
            end
            ST_CALC: begin
                if (load_fall) begin
                    pend_d = 1'b1;
                end
                if (wr_chan) begin
                    cnt_d = CNT_W'(CALC_CYCLES - 1);
                end else if (cnt_q == '0) begin
                    code_update = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_CLEAR: begin
                if (load_fall) begin
                    pend_d = 1'b1;
                end
                if (cnt_q == '0) begin
                    state_d = ST_CALC;
                    cnt_d = CNT_W'(CALC_CYCLES - 1);
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = ST_RESET;
                cnt_d = CNT_W'(RESET_CYCLES - 1);
            end
        endcase
        if (clr_fall && state_q != ST_RESET) begin
            state_d = ST_CLEAR;
            cnt_d = CNT_W'(CLEAR_CYCLES - 1);
            clear_apply = 1'b1;
            // A load that meets a clear is kept and runs once the clear and the calculation after it are over.
            if (load_exec) begin
                pend_d = 1'b1;
            end
            load_exec = 1'b0;
        end
        if (rst_start) begin
            state_d = ST_RESET;
            cnt_d = CNT_W'(RESET_CYCLES - 1);
            pend_d = 1'b0;
            toggle_d = 1'b0;
            clear_code_d = CLEAR_CODE_RESET;
            clear_apply = 1'b0;
            load_exec = 1'b0;
            code_update = 1'b0;
        end
        busy_n_d = (state_d == ST_IDLE);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_q <= ST_RESET;
            cnt_q <= CNT_W'(RESET_CYCLES - 1);
            pend_q <= 1'b0;
            toggle_q <= 1'b0;
            clear_code_q <= CLEAR_CODE_RESET;
            busy_n_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            toggle_q <= toggle_d;
            clear_code_q <= clear_code_d;
            busy_n_q <= busy_n_d;
        end
    end

    assign o_busy_n = busy_n_q;

    // ==========================================================
    // Per-channel registers
    logic [DATA_W-1:0] x2a_all [NUM_CH];

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic [DATA_W-1:0] x1a_q;
        logic [DATA_W-1:0] x1a_d;
        logic [DATA_W-1:0] x1b_q;
        logic [DATA_W-1:0] x1b_d;
        logic [DATA_W-1:0] gain_q;
        logic [DATA_W-1:0] gain_d;
        logic [DATA_W-1:0] offs_q;
        logic [DATA_W-1:0] offs_d;
        logic [DATA_W-1:0] x2a_q;
        logic [DATA_W-1:0] x2a_d;
        logic [DATA_W-1:0] x2b_q;
        logic [DATA_W-1:0] x2b_d;
        logic [DATA_W-1:0] dac_q;
        logic [DATA_W-1:0] dac_d;
        logic bank_q;
        logic bank_d;
        logic [DATA_W-1:0] calc_a;
        logic [DATA_W-1:0] calc_b;
        logic hit;

        code_calc u_calc_a (
            .i_input_code(x1a_q),
            .i_gain(gain_q),
            .i_offset(offs_q),
            .o_computed_code(calc_a)
        );

        code_calc u_calc_b (
            .i_input_code(x1b_q),
            .i_gain(gain_q),
            .i_offset(offs_q),
            .o_computed_code(calc_b)
        );

        always_comb begin
            hit = wr_chan & (s_addr == CH_W'(g));
            x1a_d = x1a_q;
            x1b_d = x1b_q;
            gain_d = gain_q;
            offs_d = offs_q;
            x2a_d = x2a_q;
            x2b_d = x2b_q;
            dac_d = dac_q;
            bank_d = bank_q;
            if (rst_start) begin
                x1a_d = INPUT_RESET;
                x1b_d = INPUT_RESET;
                gain_d = GAIN_RESET;
                offs_d = OFFSET_RESET;
                x2a_d = OUTPUT_RESET;
                x2b_d = OUTPUT_RESET;
                dac_d = OUTPUT_RESET;
                bank_d = 1'b0;
            end else begin
                if (hit) begin
                    case (s_regsel)
                        REGSEL_INPUT: begin
                            if (wr_b) begin
                                x1b_d = s_data;
                            end else begin
                                x1a_d = s_data;
                            end
                        end
                        REGSEL_GAIN: begin
                            gain_d = s_data;
                        end
                        REGSEL_OFFSET: begin
                            offs_d = s_data;
                        end
                        default: begin
                            x1a_d = x1a_q;
                        end
                    endcase
                end
                if (code_update) begin
                    x2a_d = calc_a;
                    x2b_d = calc_b;
                end
                if (clear_apply) begin
                    dac_d = clear_code_q;
                end else if (load_exec) begin
                    if (toggle_q) begin
                        bank_d = ~bank_q;
                        dac_d = bank_q ? x2a_q : x2b_q;
                    end else begin
                        bank_d = 1'b0;
                        dac_d = x2a_q;
                    end
                end
            end
        end

        always_ff @(posedge i_sys_clk) begin
            if (i_reset) begin
                x1a_q <= INPUT_RESET;
                x1b_q <= INPUT_RESET;
                gain_q <= GAIN_RESET;
                offs_q <= OFFSET_RESET;
                x2a_q <= OUTPUT_RESET;
                x2b_q <= OUTPUT_RESET;
                dac_q <= OUTPUT_RESET;
                bank_q <= 1'b0;
            end else begin
                x1a_q <= x1a_d;
                x1b_q <= x1b_d;
                gain_q <= gain_d;
                offs_q <= offs_d;
                x2a_q <= x2a_d;
                x2b_q <= x2b_d;
                dac_q <= dac_d;
                bank_q <= bank_d;
            end
        end

        assign x2a_all[g] = x2a_q;
        assign o_dac_code[g*DATA_W +: DATA_W] = dac_q;
    end

    // ==========================================================
    // Serial readback shifter
    logic [DATA_W-1:0] shreg_q;
    logic [DATA_W-1:0] shreg_d;
    logic din_q;
    logic din_d;
    logic sdo_q;
    logic sdo_d;
    logic oe_q;
    logic oe_d;
    logic frame;

    always_comb begin
        frame = s_iface & ~s_cs_n & (state_q != ST_RESET);
        shreg_d = shreg_q;
        din_d = din_q;
        sdo_d = sdo_q;
        oe_d = frame;
        if (frame && cs_fall) begin
            shreg_d = (s_rb_ch < NUM_CH_LIMIT) ? x2a_all[s_rb_ch] : '0;
        end else if (frame && sclk_rise) begin
            sdo_d = shreg_q[DATA_W-1];
            shreg_d = {shreg_q[DATA_W-2:0], din_q};
        end
        if (frame && sclk_fall) begin
            din_d = s_data[SERIAL_DIN_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            shreg_q <= '0;
            din_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            shreg_q <= shreg_d;
            din_q <= din_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
        end
    end

    assign o_serial_readback_output = sdo_q;
    assign o_serial_readback_oe = oe_q;
endmodule
`default_nettype wire

/* File: bench/dac_load_busy_control_asserts.sv */
// Port checker for the DAC load and busy control block.
`timescale 1ns/100ps
`default_nettype none
module dac_load_busy_control_asserts (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Pins
    input wire logic [dac_ctrl_pkg::CH_W-1:0] i_channel_address_inputs,
    input wire logic i_register_select_high,
    input wire logic i_register_select_low,
    input wire logic i_chip_select_n,
    input wire logic i_write_n,
    input wire logic i_interface_select,
    input wire logic i_clear_to_code_input_n,
    input wire logic i_reset_pin_n,
    // Outputs
    input wire logic o_serial_readback_oe,
    input wire logic o_busy_n,
    input wire logic [dac_ctrl_pkg::NUM_CH*dac_ctrl_pkg::DATA_W-1:0] o_dac_code
);
    import dac_ctrl_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    sequence s_busy_run;
        (!o_busy_n) [*8];
    endsequence
    sequence s_reset_done;
        $fell(i_reset) ##0 s_busy_run;
    endsequence
    sequence s_chan_write;
        $rose(i_write_n) && !i_chip_select_n && !i_interface_select && o_busy_n
            && (i_register_select_high || i_register_select_low)
            && (i_channel_address_inputs < NUM_CH_LIMIT);
    endsequence
    a_reset_busy: assert property (i_reset |=> !o_busy_n)
        else $error("busy not low in reset");
    a_reset_codes: assert property (i_reset |=> o_dac_code == '0)
        else $error("codes not cleared by reset");
    a_reset_oe: assert property (i_reset |=> !o_serial_readback_oe)
        else $error("readback driven in reset");
    a_reset_discard: assert property (s_reset_done |-> o_dac_code == '0)
        else $error("codes moved during reset sequence");
    a_parallel_no_oe: assert property ((!i_interface_select) [*4] |-> !o_serial_readback_oe)
        else $error("readback driven in parallel mode");
    a_deselect_no_oe: assert property (i_chip_select_n [*4] |-> !o_serial_readback_oe)
        else $error("readback driven while deselected");
    a_write_busy: assert property (disable iff (i_reset) s_chan_write |-> ##[2:5] s_busy_run)
        else $error("no busy after channel write");
    a_clear_busy: assert property (disable iff (i_reset)
        $fell(i_clear_to_code_input_n) |-> ##[1:6] s_busy_run)
        else $error("no busy after clear");
    a_pin_reset_busy: assert property (disable iff (i_reset)
        $fell(i_reset_pin_n) |-> ##[1:6] s_busy_run)
        else $error("no busy after reset pin");
endmodule
bind dac_load_busy_control dac_load_busy_control_asserts u_asserts (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_channel_address_inputs(i_channel_address_inputs),
    .i_register_select_high(i_register_select_high),
    .i_register_select_low(i_register_select_low),
    .i_chip_select_n(i_chip_select_n),
    .i_write_n(i_write_n),
    .i_interface_select(i_interface_select),
    .i_clear_to_code_input_n(i_clear_to_code_input_n),
    .i_reset_pin_n(i_reset_pin_n),
    .o_serial_readback_oe(o_serial_readback_oe),
    .o_busy_n(o_busy_n),
    .o_dac_code(o_dac_code)
);
`default_nettype wire

/* File: bench/host_bus_model.sv */
// Behavioural host driving the parallel write bus and serial readback frames.
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    // Clock and readback
    input wire logic i_sys_clk,
    input wire logic i_sdo,
    input wire logic i_oe,
    // Bus pins
    output logic [dac_ctrl_pkg::DATA_W-1:0] o_data,
    output logic [dac_ctrl_pkg::CH_W-1:0] o_addr,
    output logic [1:0] o_sel,
    output logic o_cs_n,
    output logic o_wr_n,
    output logic o_intf,
    output logic o_bank
);
    import dac_ctrl_pkg::*;
    initial begin
        o_data = '0;
        o_addr = '0;
        o_sel = '0;
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_intf = 1'b0;
        o_bank = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // Released address and data lines show inverted values so stale data cannot pass.
    task automatic wr(input logic [1:0] s, input logic [CH_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic b);
        gap(1);
        o_cs_n = 1'b0;
        o_sel = s;
        o_addr = a;
        o_data = d;
        o_bank = b;
        o_wr_n = 1'b0;
        gap(3);
        o_wr_n = 1'b1;
        gap(3);
        o_cs_n = 1'b1;
        o_addr = ~a;
        o_data = ~d;
    endtask
    task automatic sread(output logic [DATA_W-1:0] q, output logic oe_seen);
        o_data = '0;
        o_intf = 1'b1;
        gap(4);
        o_cs_n = 1'b0;
        gap(5);
        oe_seen = i_oe;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            o_data[SERIAL_CLK_BIT] = 1'b1;
            gap(5);
            q[i] = i_sdo;
            o_data[SERIAL_CLK_BIT] = 1'b0;
            gap(5);
        end
        o_cs_n = 1'b1;
        gap(5);
        o_intf = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/dac_load_busy_control_tb.sv */
// Self-checking testbench for the DAC load and busy control block.
`timescale 1ns/100ps
`default_nettype none
module dac_load_busy_control_tb;
    import dac_ctrl_pkg::*;
    localparam int CLR_N = 20;
    localparam int RST_N = 30;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic load_n = 1'b1;
    logic clr_n = 1'b1;
    logic rpin_n = 1'b1;
    logic [CH_W-1:0] rb_ch = '0;
    logic [DATA_W-1:0] data;
    logic [CH_W-1:0] addr;
    logic [1:0] sel;
    logic cs_n, wr_n, intf, bank, serial_readback_output, oe, busy_n, oe_seen;
    logic [DATA_W-1:0] q;
    logic [NUM_CH*DATA_W-1:0] code;
    int n_fail = 0;
    int samples_checked = 0;
    int busy_len;
    // Shared bank-select and readback pin.
    wire logic bank_pin = oe ? serial_readback_output : bank;
    always #2 sys_clk = ~sys_clk;
    dac_load_busy_control #(.CLEAR_CYCLES(CLR_N), .RESET_CYCLES(RST_N)) DUT (
        .i_sys_clk(sys_clk), .i_reset(reset), .i_parallel_data_bus(data),
        .i_channel_address_inputs(addr), .i_register_select_high(sel[1]),
        .i_register_select_low(sel[0]), .i_chip_select_n(cs_n), .i_write_n(wr_n),
        .i_interface_select(intf), .i_load_outputs_strobe_n(load_n),
        .i_clear_to_code_input_n(clr_n), .i_reset_pin_n(rpin_n),
        .i_readback_channel(rb_ch), .i_bank_select(bank_pin),
        .o_serial_readback_output(serial_readback_output), .o_serial_readback_oe(oe),
        .o_busy_n(busy_n), .o_dac_code(code));
    host_bus_model host (
        .i_sys_clk(sys_clk), .i_sdo(bank_pin), .i_oe(oe), .o_data(data),
        .o_addr(addr), .o_sel(sel), .o_cs_n(cs_n), .o_wr_n(wr_n),
        .o_intf(intf), .o_bank(bank));
    // ========================================
    // Helpers
    function automatic logic [DATA_W-1:0] ch(input int g);
        return code[g*DATA_W +: DATA_W];
    endfunction
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_idle();
        busy_len = 0;
        while (busy_n !== 1'b1 && busy_len < 500) begin
            @(negedge sys_clk);
            busy_len++;
        end
        if (busy_len == 500) begin
            n_fail++;
            $display("mismatch at %0t: busy stuck low", $time);
            final_report();
        end
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic pulse_load();
        wait_idle();
        load_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        load_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset_seq();
        load_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        load_n = 1'b1;
        check({11'h0, busy_n}, 12'h0);
        wait_idle();
        check({11'h0, busy_len >= RST_N - 8}, 12'h1);
        check(ch(0), 12'h000);
        $display("reset test done");
    endtask
    task automatic t_write_load();
        host.wr(REGSEL_INPUT, 6'h00, 12'habc, 1'b1);
        host.wr(REGSEL_INPUT, 6'h27, 12'h123, 1'b1);
        wait_idle();
        check(ch(0), 12'h000);
        pulse_load();
        check(ch(0), 12'habc);
        check(ch(39), 12'h123);
        check(ch(38), 12'h000);
        $display("write test done");
    endtask
    task automatic t_load_in_calc();
        host.wr(REGSEL_INPUT, 6'h01, 12'h456, 1'b0);
        check({11'h0, busy_n}, 12'h0);
        load_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(ch(1), 12'h000);
        load_n = 1'b1;
        wait_idle();
        check(ch(1), 12'h456);
        $display("stored load test done");
    endtask
    task automatic t_gain_offset();
        host.wr(REGSEL_GAIN, 6'h02, 12'h7ff, 1'b0);
        host.wr(REGSEL_INPUT, 6'h02, 12'h800, 1'b0);
        host.wr(REGSEL_OFFSET, 6'h03, 12'h900, 1'b0);
        host.wr(REGSEL_INPUT, 6'h03, 12'h100, 1'b0);
        pulse_load();
        check(ch(2), 12'h400);
        check(ch(3), 12'h200);
        $display("gain offset test done");
    endtask
    task automatic t_toggle();
        host.wr(REGSEL_SFR, SFR_CONTROL, 12'h001, 1'b0);
        host.wr(REGSEL_INPUT, 6'h04, 12'h111, 1'b0);
        host.wr(REGSEL_INPUT, 6'h04, 12'h222, 1'b1);
        pulse_load();
        check(ch(4), 12'h222);
        pulse_load();
        check(ch(4), 12'h111);
        host.wr(REGSEL_SFR, SFR_CONTROL, 12'h000, 1'b0);
        $display("toggle test done");
    endtask
    task automatic t_serial();
        wait_idle();
        host.sread(q, oe_seen);
        check(q, 12'habc);
        check({11'h0, oe_seen}, 12'h1);
        check({11'h0, oe}, 12'h0);
        $display("serial test done");
    endtask
    task automatic t_clear();
        host.wr(REGSEL_SFR, SFR_CLEAR_CODE, 12'h5a5, 1'b0);
        wait_idle();
        clr_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(ch(0), 12'h5a5);
        check(ch(39), 12'h5a5);
        clr_n = 1'b1;
        wait_idle();
        check({11'h0, busy_len >= CLR_N - 5}, 12'h1);
        $display("clear test done");
    endtask
    task automatic t_pin_reset();
        rpin_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        check({11'h0, busy_n}, 12'h0);
        wait_idle();
        check({11'h0, busy_len >= RST_N - 3}, 12'h1);
        host.wr(REGSEL_INPUT, 6'h05, 12'h321, 1'b0);
        pulse_load();
        check(ch(5), 12'h321);
        check(ch(0), 12'h000);
        rpin_n = 1'b1;
        $display("pin reset test done");
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        t_reset_seq();
        t_write_load();
        t_load_in_calc();
        t_gain_offset();
        t_toggle();
        t_serial();
        t_clear();
        t_pin_reset();
        final_report();
    end
endmodule
`default_nettype wire
